// *** modbus_io_register_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "io_bank_map.svh"
// Functional notes
// - all data held as 16-bit registers
// - coils, inputs, input and holding registers
// - RTU or ASCII framing, both ends match
// - rate codes 0..6, else value times ten
// - parity none/odd/even/mark/space select
// - low byte sets stop bits
// - high byte sets data bits
// - wait reply delay ms before reply
// - framing register 0 RTU, 1 ASCII
// - watchdog forces outputs to default
// - watchdog resets zero, zero disables
// - default pattern at reset and expiry
// - received frame counter, high first
// - error frame counter, high first
// - captured copies of both pulse counters
// - first input register is version code
// - reply light lit while answering
// - input and output lights follow levels
// - counter setup bits select behaviour
module modbus_io_register_bank
   import io_bank_pkg::*;
#(
   parameter logic [15:0] VERSION_CODE = 16'h0100, // arbitrary value
   parameter int CLK_HZ = `CLK_HZ
)
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   input wire logic frame_ok_in,
   input wire logic frame_bad_in,
   input wire logic reply_req_in,
   input wire logic reply_done_in,
   output logic reply_go_out,
   output logic [1:0] din_in_unused_out,
   input wire logic [1:0] din_in,
   output logic [1:0] dout_out,
   output logic reply_light_out,
   output logic first_input_light_out,
   output logic second_input_light_out,
   output logic first_output_light_out,
   output logic second_output_light_out,
   output logic [31:0] baud_rate_out,
   output logic [1:0] stop_bits_out,
   output logic [3:0] data_bits_out,
   output parity_mode_t parity_out,
   output logic ascii_mode_out
);
   localparam int MS_CYC = (CLK_HZ / `MS_PER_S) < 1 ? 1 : CLK_HZ / `MS_PER_S;
   localparam int SEC_MS = `MS_PER_S;

   logic [15:0] rate, next_rate, chr, next_chr, par, next_par;
   logic [15:0] delay, next_delay, framing, next_framing, timeout, next_timeout;
   logic [15:0] fallback, next_fallback, outs, next_outs;
   logic [15:0] setup_a, next_setup_a, setup_b, next_setup_b;
   logic [31:0] rx_cnt, next_rx_cnt, bad_cnt, next_bad_cnt, tx_cnt, next_tx_cnt;
   logic [31:0] cnt_a, next_cnt_a, cnt_b, next_cnt_b;
   logic [31:0] held_a, next_held_a, held_b, next_held_b;
   logic [1:0] din_q, next_din_q;
   logic [31:0] ms_div, next_ms_div;
   logic ms_tick;
   logic [15:0] wd_ms, next_wd_ms;
   logic [15:0] dly_ms, next_dly_ms;
   logic [9:0] sec_ms, next_sec_ms;
   reply_state_t rs, next_rs;
   logic wd_fire;
   logic [15:0] rdata, next_rdata;

   // millisecond tick
   // divider runs free; watchdog, reply delay and counters share it
   always_comb
   begin
      ms_tick = (ms_div == 32'(MS_CYC - 1));
      next_ms_div = ms_tick ? 32'h0000_0000 : ms_div + 32'h0000_0001;
   end

   // communication watchdog
   always_comb
   begin
      wd_fire = 1'b0;
      next_wd_ms = wd_ms;
      if (frame_ok_in || timeout == `RST_ZERO)
         next_wd_ms = 16'h0000;
      else if (ms_tick)
      begin
         // first tick after a restart may come at once, so one tick
         // more keeps the interval at least the programmed length
         if (wd_ms >= timeout)
         begin
            wd_fire = 1'b1;
            next_wd_ms = 16'h0000;
         end
         else
            next_wd_ms = wd_ms + 16'h0001;
      end
   end

   // reply sequencer with delay
   always_comb
   begin
      next_rs = rs;
      next_dly_ms = dly_ms;
      case (rs)
         RS_IDLE:
         begin
            next_dly_ms = 16'h0000;
            if (reply_req_in)
               next_rs = (delay == `RST_ZERO) ? RS_SEND : RS_WAIT;
         end
         RS_WAIT:
         begin
            if (ms_tick)
            begin
               next_dly_ms = dly_ms + 16'h0001;
               // one extra tick, as the first may follow at once
               if (dly_ms >= delay)
                  next_rs = RS_SEND;
            end
         end
         RS_SEND:
         begin
            if (reply_done_in)
               next_rs = RS_IDLE;
         end
         default: next_rs = RS_IDLE;
      endcase
   end

   // register writes, counters and capture
   always_comb
   begin
      next_rate = rate;
      next_chr = chr;
      next_par = par;
      next_delay = delay;
      next_framing = framing;
      next_timeout = timeout;
      next_fallback = fallback;
      next_outs = outs;
      next_setup_a = setup_a;
      next_setup_b = setup_b;
      next_rx_cnt = rx_cnt + {31'h0, frame_ok_in | frame_bad_in};
      next_bad_cnt = bad_cnt + {31'h0, frame_bad_in};
      next_tx_cnt = tx_cnt + {31'h0, (rs == RS_SEND) & reply_done_in};
      next_din_q = din_in;
      next_sec_ms = ms_tick ? ((sec_ms == 10'(SEC_MS - 1)) ? 10'h000 : sec_ms + 10'h001) : sec_ms;
      next_cnt_a = cnt_a;
      next_cnt_b = cnt_b;
      next_held_a = held_a;
      next_held_b = held_b;
      // counter a
      if (setup_a[`SET_ENCODER])
      begin
         if (din_in[0] & ~din_q[0])
            next_cnt_a = din_in[1] ? cnt_a - 32'h0000_0001 : cnt_a + 32'h0000_0001;
      end
      else if (setup_a[`SET_TIME])
      begin
         if (din_in[0] & ms_tick)
            next_cnt_a = cnt_a + 32'h0000_0001;
      end
      else if (din_in[0] & ~din_q[0])
         next_cnt_a = cnt_a + 32'h0000_0001;
      if ((setup_a[`SET_AUTO] & ms_tick & sec_ms == 10'(SEC_MS - 1)) |
          (setup_a[`SET_CAP_LOW] & ~din_in[0] & din_q[0]))
      begin
         next_held_a = cnt_a;
         if (setup_a[`SET_CLR_CAP])
            next_cnt_a = 32'h0000_0000;
      end
      if (setup_a[`SET_CLR_LOW] & ~din_in[0])
         next_cnt_a = 32'h0000_0000;
      // input 1 sets the direction in encoder mode, so b counts no edges; b still counts in its time mode
      // counter b
      if (setup_b[`SET_TIME])
      begin
         if (din_in[1] & ms_tick)
            next_cnt_b = cnt_b + 32'h0000_0001;
      end
      else if (din_in[1] & ~din_q[1] & ~setup_a[`SET_ENCODER])
         next_cnt_b = cnt_b + 32'h0000_0001;
      if ((setup_b[`SET_AUTO] & ms_tick & sec_ms == 10'(SEC_MS - 1)) |
          (setup_b[`SET_CAP_LOW] & ~din_in[1] & din_q[1]))
      begin
         next_held_b = cnt_b;
         if (setup_b[`SET_CLR_CAP])
            next_cnt_b = 32'h0000_0000;
      end
      if (setup_b[`SET_CLR_LOW] & ~din_in[1])
         next_cnt_b = 32'h0000_0000;
      // watchdog restores fallback pattern
      // repeats every interval until a valid frame arrives
      if (wd_fire)
         next_outs = fallback;
      // holding register writes win over counting
      // read-only and unmapped offsets fall to the default branch
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            `OFS_RATE: next_rate = reg_wdata_in;
            `OFS_CHAR: next_chr = reg_wdata_in;
            `OFS_PARITY: next_par = reg_wdata_in;
            `OFS_DELAY: next_delay = reg_wdata_in;
            `OFS_FRAMING: next_framing = reg_wdata_in;
            `OFS_TIMEOUT: next_timeout = reg_wdata_in;
            `OFS_FALLBACK: next_fallback = reg_wdata_in;
            `OFS_OUTPUTS: next_outs = reg_wdata_in;
            `OFS_SETUP_A: next_setup_a = reg_wdata_in;
            `OFS_SETUP_B: next_setup_b = reg_wdata_in;
            `OFS_RX_HI: next_rx_cnt[31:16] = reg_wdata_in;
            `OFS_RX_LO: next_rx_cnt[15:0] = reg_wdata_in;
            `OFS_BAD_HI: next_bad_cnt[31:16] = reg_wdata_in;
            `OFS_BAD_LO: next_bad_cnt[15:0] = reg_wdata_in;
            `OFS_TX_HI: next_tx_cnt[31:16] = reg_wdata_in;
            `OFS_TX_LO: next_tx_cnt[15:0] = reg_wdata_in;
            `OFS_CNT_A_HI: next_cnt_a[31:16] = reg_wdata_in;
            `OFS_CNT_A_LO: next_cnt_a[15:0] = reg_wdata_in;
            `OFS_CNT_B_HI: next_cnt_b[31:16] = reg_wdata_in;
            `OFS_CNT_B_LO: next_cnt_b[15:0] = reg_wdata_in;
            `OFS_HELD_A_HI: next_held_a[31:16] = reg_wdata_in;
            `OFS_HELD_A_LO: next_held_a[15:0] = reg_wdata_in;
            `OFS_HELD_B_HI: next_held_b[31:16] = reg_wdata_in;
            `OFS_HELD_B_LO: next_held_b[15:0] = reg_wdata_in;
            default: next_rate = rate;
         endcase
      end
   end

   // read mux, high half at lower offset
   always_comb
   begin
      case (reg_addr_in)
         `OFS_VERSION: next_rdata = VERSION_CODE;
         `OFS_NODE: next_rdata = `RST_NODE;
         `OFS_RATE: next_rdata = rate;
         `OFS_CHAR: next_rdata = chr;
         `OFS_PARITY: next_rdata = par;
         `OFS_DELAY: next_rdata = delay;
         `OFS_FRAMING: next_rdata = framing;
         `OFS_TIMEOUT: next_rdata = timeout;
         `OFS_FALLBACK: next_rdata = fallback;
         `OFS_RX_HI: next_rdata = rx_cnt[31:16];
         `OFS_RX_LO: next_rdata = rx_cnt[15:0];
         `OFS_BAD_HI: next_rdata = bad_cnt[31:16];
         `OFS_BAD_LO: next_rdata = bad_cnt[15:0];
         `OFS_TX_HI: next_rdata = tx_cnt[31:16];
         `OFS_TX_LO: next_rdata = tx_cnt[15:0];
         `OFS_INPUTS: next_rdata = {14'h0000, din_in};
         `OFS_OUTPUTS: next_rdata = outs;
         `OFS_CNT_A_HI: next_rdata = cnt_a[31:16];
         `OFS_CNT_A_LO: next_rdata = cnt_a[15:0];
         `OFS_CNT_B_HI: next_rdata = cnt_b[31:16];
         `OFS_CNT_B_LO: next_rdata = cnt_b[15:0];
         `OFS_HELD_A_HI: next_rdata = held_a[31:16];
         `OFS_HELD_A_LO: next_rdata = held_a[15:0];
         `OFS_HELD_B_HI: next_rdata = held_b[31:16];
         `OFS_HELD_B_LO: next_rdata = held_b[15:0];
         `OFS_SETUP_A: next_rdata = setup_a;
         `OFS_SETUP_B: next_rdata = setup_b;
         default: next_rdata = 16'h0000;
      endcase
   end

   // state registers
   // outputs and fallback pattern both start cleared
   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         rate <= `RST_RATE;
         chr <= `RST_CHAR;
         par <= `RST_ZERO;
         delay <= `RST_ZERO;
         framing <= `RST_ZERO;
         timeout <= `RST_ZERO;
         fallback <= `RST_ZERO;
         outs <= `RST_ZERO;
         setup_a <= `RST_ZERO;
         setup_b <= `RST_ZERO;
         rx_cnt <= 32'h0000_0000;
         bad_cnt <= 32'h0000_0000;
         tx_cnt <= 32'h0000_0000;
         cnt_a <= 32'h0000_0000;
         cnt_b <= 32'h0000_0000;
         held_a <= 32'h0000_0000;
         held_b <= 32'h0000_0000;
         din_q <= 2'h0;
         ms_div <= 32'h0000_0000;
         sec_ms <= 10'h000;
         wd_ms <= 16'h0000;
         dly_ms <= 16'h0000;
         rs <= RS_IDLE;
         rdata <= 16'h0000;
      end
      else if (ce_in)
      begin
         rate <= next_rate;
         chr <= next_chr;
         par <= next_par;
         delay <= next_delay;
         framing <= next_framing;
         timeout <= next_timeout;
         fallback <= next_fallback;
         outs <= next_outs;
         setup_a <= next_setup_a;
         setup_b <= next_setup_b;
         rx_cnt <= next_rx_cnt;
         bad_cnt <= next_bad_cnt;
         tx_cnt <= next_tx_cnt;
         cnt_a <= next_cnt_a;
         cnt_b <= next_cnt_b;
         held_a <= next_held_a;
         held_b <= next_held_b;
         din_q <= next_din_q;
         ms_div <= next_ms_div;
         sec_ms <= next_sec_ms;
         wd_ms <= next_wd_ms;
         dly_ms <= next_dly_ms;
         rs <= next_rs;
         rdata <= next_rdata;
      end
   end

   // line settings decode
   // codes above six give the rate in tens of baud
   always_comb
   begin
      case (rate)
         16'h0000: baud_rate_out = 32'h0000_0960;
         16'h0001: baud_rate_out = 32'h0000_12C0;
         16'h0002: baud_rate_out = 32'h0000_2580;
         16'h0003: baud_rate_out = 32'h0000_4B00;
         16'h0004: baud_rate_out = 32'h0000_9600;
         16'h0005: baud_rate_out = 32'h0000_E100;
         16'h0006: baud_rate_out = 32'h0001_C200;
         default: baud_rate_out = {16'h0000, rate} * `BAUD_UNIT;
      endcase
      case (par[2:0])
         3'h1: parity_out = PAR_ODD;
         3'h2: parity_out = PAR_EVEN;
         3'h3: parity_out = PAR_MARK;
         3'h4: parity_out = PAR_SPACE;
         default: parity_out = PAR_NONE;
      endcase
   end

   // outputs and lights
   // lights are plain copies, so they show the level at once
   assign stop_bits_out = (chr[7:0] == 8'h02) ? 2'h2 : 2'h1;
   assign data_bits_out = (chr[15:8] == 8'h07) ? 4'h7 : 4'h8;
   assign ascii_mode_out = framing[0];
   assign reply_go_out = (rs == RS_SEND);
   assign reply_light_out = (rs == RS_SEND);
   assign reg_rdata_out = rdata;
   assign dout_out = outs[1:0];
   assign din_in_unused_out = din_q;
   assign first_input_light_out = din_in[0];
   assign second_input_light_out = din_in[1];
   assign first_output_light_out = outs[0];
   assign second_output_light_out = outs[1];
endmodule // modbus_io_register_bank
`default_nettype wire

// *** io_bank_map.svh ***
`ifndef IO_BANK_MAP_SVH
`define IO_BANK_MAP_SVH
// register offsets (word index)
`define OFS_VERSION      8'h00
`define OFS_NODE         8'h01
`define OFS_RATE         8'h02
`define OFS_CHAR         8'h03
`define OFS_PARITY       8'h04
`define OFS_DELAY        8'h05
`define OFS_FRAMING      8'h06
`define OFS_TIMEOUT      8'h08
`define OFS_FALLBACK     8'h0C
`define OFS_RX_HI        8'h20
`define OFS_RX_LO        8'h21
`define OFS_BAD_HI       8'h22
`define OFS_BAD_LO       8'h23
`define OFS_TX_HI        8'h24
`define OFS_TX_LO        8'h25
`define OFS_INPUTS       8'h32
`define OFS_OUTPUTS      8'h33
`define OFS_CNT_A_HI     8'h34
`define OFS_CNT_A_LO     8'h35
`define OFS_CNT_B_HI     8'h36
`define OFS_CNT_B_LO     8'h37
`define OFS_HELD_A_HI    8'h3C
`define OFS_HELD_A_LO    8'h3D
`define OFS_HELD_B_HI    8'h3E
`define OFS_HELD_B_LO    8'h3F
`define OFS_SETUP_A      8'h44
`define OFS_SETUP_B      8'h45
// reset values
`define RST_NODE         16'h0001
`define RST_RATE         16'h0003
`define RST_CHAR         16'h0801
`define RST_ZERO         16'h0000
// setup word bit positions
`define SET_TIME         0
`define SET_AUTO         1
`define SET_CAP_LOW      2
`define SET_CLR_CAP      3
`define SET_CLR_LOW      4
`define SET_ENCODER      5
// timing
`define CLK_HZ           50000000
`define MS_PER_S         1000
`define BAUD_UNIT        10
`endif

// *** io_bank_pkg.sv ***
package io_bank_pkg;
   typedef enum logic [4:0] {
      PAR_NONE = 5'h01,
      PAR_ODD = 5'h02,
      PAR_EVEN = 5'h04,
      PAR_MARK = 5'h08,
      PAR_SPACE = 5'h10
   } parity_mode_t;
   typedef enum logic [2:0] {
      RS_IDLE = 3'h1,
      RS_WAIT = 3'h2,
      RS_SEND = 3'h4
   } reply_state_t;
endpackage

// *** modbus_io_register_bank_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "io_bank_map.svh"
module modbus_io_register_bank_monitor
   import io_bank_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reply_done_in,
   input wire logic reply_go_out,
   input wire logic [1:0] din_in,
   input wire logic [1:0] dout_out,
   input wire logic reply_light_out,
   input wire logic first_input_light_out,
   input wire logic second_input_light_out,
   input wire logic first_output_light_out,
   input wire logic second_output_light_out,
   input wire logic [31:0] baud_rate_out,
   input wire logic [1:0] stop_bits_out,
   input wire logic [3:0] data_bits_out,
   input wire parity_mode_t parity_out,
   input wire logic ascii_mode_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   // line rate expected for a code
   function automatic logic [31:0] rate_of(input logic [15:0] c);
      case (c)
         16'h0000: return 32'd2400;
         16'h0001: return 32'd4800;
         16'h0002: return 32'd9600;
         16'h0003: return 32'd19200;
         16'h0004: return 32'd38400;
         16'h0005: return 32'd57600;
         16'h0006: return 32'd115200;
         default: return c * 32'd10;
      endcase
   endfunction
   // decoded settings follow the register writes
   a_rate_decode: assert property (
      ce_in && reg_wr_in && reg_addr_in == `OFS_RATE |=> baud_rate_out == rate_of($past(reg_wdata_in)))
      else $error("line rate decode wrong");
   a_parity_select: assert property (
      ce_in && reg_wr_in && reg_addr_in == `OFS_PARITY && reg_wdata_in < 16'h0005
      |=> parity_out == (5'h01 << $past(reg_wdata_in[2:0]))) else $error("parity select wrong");
   a_char_format: assert property (
      ce_in && reg_wr_in && reg_addr_in == `OFS_CHAR && reg_wdata_in[7:0] inside {8'h01, 8'h02}
      && reg_wdata_in[15:8] inside {8'h07, 8'h08} |=> stop_bits_out == $past(reg_wdata_in[1:0])
      && data_bits_out == $past(reg_wdata_in[11:8])) else $error("character format wrong");
   a_framing_mode: assert property (
      ce_in && reg_wr_in && reg_addr_in == `OFS_FRAMING && reg_wdata_in < 16'h0002
      |=> ascii_mode_out == $past(reg_wdata_in[0])) else $error("framing mode wrong");
   a_output_write: assert property (
      ce_in && reg_wr_in && reg_addr_in == `OFS_OUTPUTS |=> dout_out == $past(reg_wdata_in[1:0]))
      else $error("output write lost");
   a_reply_ends: assert property (
      ce_in && reply_go_out && reply_done_in |=> !reply_go_out) else $error("reply did not end");
   // lights mirror their sources
   a_reply_light: assert property (
      reply_light_out && !(ce_in && reply_done_in) |=> reply_light_out && reply_go_out)
      else $error("reply light dropped early");
   a_input_lights: assert property (
      {second_input_light_out, first_input_light_out} == din_in) else $error("input lights wrong");
   a_output_lights: assert property (
      {second_output_light_out, first_output_light_out} == dout_out) else $error("output lights wrong");
   c_reply_done: cover property (reply_go_out && reply_done_in);
   c_timeout_set: cover property (reg_wr_in && reg_addr_in == `OFS_TIMEOUT);
   c_output_drop: cover property ($fell(dout_out[0]));
endmodule // modbus_io_register_bank_monitor
bind modbus_io_register_bank modbus_io_register_bank_monitor i_mon (.clk_sys_in, .resetn_in, .ce_in,
   .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reply_done_in, .reply_go_out, .din_in, .dout_out,
   .reply_light_out, .first_input_light_out, .second_input_light_out, .first_output_light_out,
   .second_output_light_out, .baud_rate_out, .stop_bits_out, .data_bits_out, .parity_out, .ascii_mode_out);
`default_nettype wire

// *** link_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module link_partner
(
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [7:0] lat_in,
   output logic done_out
);
   int n = 0;
   initial done_out = 1'b0;
   // transmitter: finishes a permitted reply lat_in + 1 cycles after go_in rises
   always @(negedge clk_in)
   begin
      done_out <= 1'b0;
      if (!go_in || done_out)
         n <= 0;
      else if (n == lat_in)
      begin
         done_out <= 1'b1;
         n <= 0;
      end
      else
         n <= n + 1;
   end
endmodule // link_partner
`default_nettype wire

// *** modbus_io_register_bank_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "io_bank_map.svh"
module modbus_io_register_bank_tb;
   import io_bank_pkg::*;
   localparam logic [15:0] VER = 16'h5A3C; // arbitrary value
   logic clk_sys_in = 0, resetn_in = 0, wr = 0, fok = 0, fbad = 0, req = 0, done, pend = 0, ce = 1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, v;
   logic [1:0] din = 2'h0, dout, dq;
   logic go, rl, l0, l1, o0, o1, ascii;
   logic [31:0] baud;
   logic [1:0] stop;
   logic [3:0] dbits;
   parity_mode_t par;
   logic [15:0] q[$];
   logic [31:0] rates[7] = '{32'd2400, 32'd4800, 32'd9600, 32'd19200, 32'd38400, 32'd57600, 32'd115200};
   int n_errors = 0, n_compared = 0;
   modbus_io_register_bank #(.VERSION_CODE(VER), .CLK_HZ(10000)) i_modbus_io_register_bank (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .frame_ok_in(fok), .frame_bad_in(fbad),
      .reply_req_in(req), .reply_done_in(done), .reply_go_out(go), .din_in_unused_out(dq), .din_in(din),
      .dout_out(dout), .reply_light_out(rl), .first_input_light_out(l0), .second_input_light_out(l1),
      .first_output_light_out(o0), .second_output_light_out(o1), .baud_rate_out(baud),
      .stop_bits_out(stop), .data_bits_out(dbits), .parity_out(par), .ascii_mode_out(ascii));
   link_partner i_link_partner (.clk_in(clk_sys_in), .go_in(go), .lat_in(8'h03), .done_out(done));
   // clock at 50 MHz
   initial forever #10 clk_sys_in = ~clk_sys_in;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task complete_run;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk_sys_in);
      wr = 0;
      @(negedge clk_sys_in);
   endtask
   task rd_reg(input logic [7:0] a, input logic [15:0] e);
      addr = a;
      q.push_back(e);
      pend <= 1;
      @(negedge clk_sys_in);
      pend <= 0;
      @(negedge clk_sys_in);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge clk_sys_in);
      s = 0;
      @(negedge clk_sys_in);
   endtask
   task wait_go(input logic e);
      int k;
      k = 0;
      while (go !== e && k < 60)
      begin
         @(negedge clk_sys_in);
         k++;
      end
      check("reply_go", go, e);
   endtask
   // read data compared the cycle after each address
   always @(negedge clk_sys_in)
      if (pend)
         check("rdata", rdata, q.pop_front());
   // hang guard
   initial
   begin
      #400000;
      n_errors++;
      complete_run();
   end
   initial
   begin
      repeat (10) @(negedge clk_sys_in);
      resetn_in = 1;
      v = 16'($urandom(32'h931E));
      rd_reg(`OFS_VERSION, VER);
      rd_reg(`OFS_NODE, `RST_NODE);
      rd_reg(`OFS_RATE, `RST_RATE);
      rd_reg(`OFS_CHAR, `RST_CHAR);
      rd_reg(`OFS_DELAY, 16'h0000);
      rd_reg(`OFS_TIMEOUT, 16'h0000);
      rd_reg(`OFS_HELD_A_HI, 16'h0000);
      $display("test reset values done");
      for (int i = 0; i < 8; i++)
      begin
         v = (i < 7) ? 16'(i) : 16'($urandom_range(7, 16'hFFFF));
         wr_reg(`OFS_RATE, v);
         check("baud", baud, (i < 7) ? rates[i] : 32'(v) * 32'd10);
      end
      for (int p = 0; p < 5; p++)
      begin
         wr_reg(`OFS_PARITY, 16'(p));
         check("parity", par, 32'h1 << p);
      end
      for (int d = 7; d < 9; d++)
         for (int s = 1; s < 3; s++)
         begin
            wr_reg(`OFS_CHAR, {8'(d), 8'(s)});
            check("stop", stop, s);
            check("data", dbits, d);
         end
      for (int m = 0; m < 2; m++)
      begin
         wr_reg(`OFS_FRAMING, 16'(m));
         check("ascii", ascii, m);
         rd_reg(`OFS_FRAMING, 16'(m));
      end
      $display("test line settings done");
      wr_reg(`OFS_VERSION, 16'($urandom));
      rd_reg(`OFS_VERSION, VER);
      wr_reg(8'h7F, 16'hBEEF);
      rd_reg(8'h7F, 16'h0000);
      din = 2'($urandom);
      @(negedge clk_sys_in);
      check("in_lights", {l1, l0}, din);
      check("din_q", dq, din);
      rd_reg(`OFS_INPUTS, {14'h0, din});
      v = 16'($urandom);
      wr_reg(`OFS_HELD_B_LO, v);
      rd_reg(`OFS_HELD_B_LO, v);
      $display("test access kinds done");
      repeat (3) pulse(fok);
      repeat (2) pulse(fbad);
      rd_reg(`OFS_RX_LO, 16'h0005);
      rd_reg(`OFS_BAD_LO, 16'h0002);
      rd_reg(`OFS_BAD_HI, 16'h0000);
      wr_reg(`OFS_RX_LO, 16'hFFFF);
      wr_reg(`OFS_RX_HI, 16'h0001);
      pulse(fok);
      rd_reg(`OFS_RX_HI, 16'h0002);
      rd_reg(`OFS_RX_LO, 16'h0000);
      // clock enable low freezes counting and writes
      ce = 0;
      pulse(fok);
      wr_reg(`OFS_RX_LO, 16'h1234);
      ce = 1;
      rd_reg(`OFS_RX_LO, 16'h0000);
      $display("test frame counters done");
      din = 2'h0;
      wr_reg(`OFS_CNT_A_LO, 16'h0000);
      repeat (3)
      begin
         din = 2'h1;
         @(negedge clk_sys_in);
         din = 2'h0;
         @(negedge clk_sys_in);
      end
      rd_reg(`OFS_CNT_A_LO, 16'h0003);
      wr_reg(`OFS_SETUP_A, 16'((1 << `SET_CAP_LOW) | (1 << `SET_CLR_CAP)));
      din = 2'h1;
      @(negedge clk_sys_in);
      din = 2'h0;
      @(negedge clk_sys_in);
      rd_reg(`OFS_HELD_A_LO, 16'h0004);
      rd_reg(`OFS_CNT_A_LO, 16'h0000);
      $display("test pulse counters done");
      req = 1;
      @(negedge clk_sys_in);
      req = 0;
      check("reply_go", go, 1);
      check("reply_light", rl, 1);
      wait_go(0);
      wr_reg(`OFS_DELAY, 16'h0003);
      req = 1;
      @(negedge clk_sys_in);
      req = 0;
      repeat (17) @(negedge clk_sys_in);
      check("reply_go", go, 0);
      wait_go(1);
      wait_go(0);
      rd_reg(`OFS_TX_LO, 16'h0002);
      $display("test reply done");
      wr_reg(`OFS_FALLBACK, 16'h0002);
      wr_reg(`OFS_OUTPUTS, 16'h0001);
      check("dout", dout, 2'h1);
      check("out_lights", {o1, o0}, 2'h1);
      wr_reg(`OFS_TIMEOUT, 16'h0005);
      repeat (4)
      begin
         repeat (20) @(negedge clk_sys_in);
         pulse(fok);
      end
      repeat (32) @(negedge clk_sys_in);
      check("dout", dout, 2'h1);
      repeat (30) @(negedge clk_sys_in);
      check("dout", dout, 2'h2);
      wr_reg(`OFS_TIMEOUT, 16'h0000);
      wr_reg(`OFS_OUTPUTS, 16'h0001);
      repeat (200) @(negedge clk_sys_in);
      check("dout", dout, 2'h1);
      $display("test watchdog done");
      resetn_in = 0;
      @(negedge clk_sys_in);
      resetn_in = 1;
      check("dout", dout, 2'h0);
      rd_reg(`OFS_TIMEOUT, 16'h0000);
      rd_reg(`OFS_RX_HI, 16'h0000);
      $display("test second reset done");
      complete_run();
   end
endmodule // modbus_io_register_bank_tb
`default_nettype wire
